//--- fmr_monitor.sv
// Fault monitor: sensor filtering, integrity checks, reset and exception response
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Out-of-range parameter forces reset or raises a software exception.
// (RULE2) Voltage, clock, temperature sensed; supply, clock, reset flags filtered first.
// (RULE3) Light sensor hits are reported as a fault.
// (RULE4) Software enable bit gates the EEPROM double-read check.
// (RULE5) RAM parity checked on every RAM read.
// (RULE6) Background parity scan, random order, only on idle RAM cycles.
// (RULE7) Any RAM parity error forces a security reset.
// (RULE8) Reset restores all state and leaves a readable reset cause; a forced reset keeps stack limits, PDC and LFSR.
// (RULE9) Every exception records a readable reason.
// (RULE10) No software path can disable sensors; such writes do nothing.
// (RULE11) Three stack limit checkers: user, system, super system.
// (RULE12) Active stack pointer outside limits raises an exception.
// (RULE13) Fetch-integrity alarms from listed units cover CPU, MMU, bus, copy, config.
// (RULE14) Watchdog idle until software enables it, then guards execution.
// (RULE15) Programming high voltage checked each EEPROM write; result readable.
// (RULE16) Bad high voltage only updates status, never reset or exception.
// (RULE17) Inverted ECC option turns every ECC error into an exception.
// (RULE18) Using a configuration-disabled coprocessor raises an exception.
// (RULE19) Post-delivery config rewritable until lock key; then frozen forever; sys_rst clears PDC and its lock.
// (RULE20) Without inverted ECC, single-bit byte errors are corrected silently.
// (RULE21) Simultaneous reset and exception faults: reset wins and is recorded.
// (RULE22) Cause indicators hold until software clears or next reset.
module fmr_monitor (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // Raw sensor alarms
  input  wire logic                     volt_alarm,
  input  wire logic                     clk_alarm,
  input  wire logic                     temp_alarm,
  input  wire logic                     light_alarm,
  // Integrity checks
  input  wire logic [12:0]              fetch_alarm,
  input  wire logic                     ram_rd,
  input  wire logic                     ram_par_err,
  input  wire logic                     ram_busy,
  input  wire logic                     scan_par_err,
  // Stack
  input  wire logic [2:0]               cpu_mode,
  input  wire logic [fmr_pkg::SP_W-1:0] sp_value,
  // EEPROM
  input  wire logic                     ee_ecc_err,
  input  wire logic                     ee_write_seq,
  input  wire logic                     ee_hv_ok,
  // Coprocessor use attempts
  input  wire logic                     pk_access,
  input  wire logic                     sym_access,
  // Core-side outputs
  output logic                          sec_reset,
  output logic                          exc_req,
  output logic                          ee_dread_en,
  output logic                          ee_ecc_correct,
  output logic                          scan_rd,
  output logic [fmr_pkg::RAM_AW-1:0]    scan_addr,
  output logic                          pk_enable,
  output logic                          sym_enable
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                    pready;
    logic [31:0]             prdata;
    logic                    sec_reset;
    logic                    exc_req;
    logic                    scan_rd;
    logic [fmr_pkg::RC_W-1:0] rst_cause;
    logic [fmr_pkg::EC_W-1:0] exc_cause;
    logic [3:0]              ctrl;
    logic [31:0]             wdg_load;
    logic [31:0]             wdg_cnt;
    logic [1:0]              hv_stat;
    logic [2:0][fmr_pkg::SP_W-1:0] sp_lo;
    logic [2:0][fmr_pkg::SP_W-1:0] sp_hi;
    logic [1:0]              pdc;
    logic                    pdc_locked;
    logic [15:0]             lfsr;
    logic [3:0][fmr_pkg::FILT_LEN-1:0] filt;
    logic                    hv_seen;
  } fmr_state_t;

  fmr_state_t st_reg;
  fmr_state_t st_next;

  // Stack checker for one register set
  function automatic logic sp_out(input logic [fmr_pkg::SP_W-1:0] sp,
                                  input logic [fmr_pkg::SP_W-1:0] lo,
                                  input logic [fmr_pkg::SP_W-1:0] hi);
    sp_out = (sp < lo) || (sp > hi);
  endfunction

  logic [3:0] raw_alarm;
  logic [3:0] filt_alarm;
  logic [2:0] sp_bad;
  logic       wr_acc;
  logic       rd_acc;

  assign raw_alarm = {light_alarm, temp_alarm, clk_alarm, volt_alarm};
  assign wr_acc = psel && penable && pwrite && st_reg.pready;
  // Read decoded in the setup cycle so prdata stands with pready
  assign rd_acc = psel && !penable && !pwrite;

  // ****************************************
  // Sensor filters and stack checkers
  // ****************************************
  // Glitch filter: alarm must persist for the whole window, rejects noise spikes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      assign filt_alarm[gi] = &st_reg.filt[gi]; // [RULE2] [RULE3]
    end
    for (gi = 0; gi < 3; gi++) begin : g_sp
      assign sp_bad[gi] = cpu_mode[gi] &&
                          sp_out(sp_value, st_reg.sp_lo[gi], st_reg.sp_hi[gi]); // [RULE11]
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [fmr_pkg::RC_W-1:0] rst_ev;
    logic [fmr_pkg::EC_W-1:0] exc_ev;
    logic [31:0]              rd;
    rst_ev = '0;
    exc_ev = '0;
    rd = 32'h0000_0000;
    st_next = st_reg;

    for (int i = 0; i < 4; i++) begin
      st_next.filt[i] = {st_reg.filt[i][fmr_pkg::FILT_LEN-2:0], raw_alarm[i]};
    end

    // Reset-forcing faults
    rst_ev[fmr_pkg::RC_VOLT]   = filt_alarm[0]; // [RULE1] [RULE2]
    rst_ev[fmr_pkg::RC_CLK]    = filt_alarm[1];
    rst_ev[fmr_pkg::RC_TEMP]   = filt_alarm[2];
    rst_ev[fmr_pkg::RC_LIGHT]  = filt_alarm[3]; // [RULE3]
    rst_ev[fmr_pkg::RC_RAMPAR] = ram_rd && ram_par_err; // [RULE5] [RULE7]
    rst_ev[fmr_pkg::RC_SCANPAR] = st_reg.scan_rd && scan_par_err; // [RULE6] [RULE7]
    rst_ev[fmr_pkg::RC_FETCH]  = |fetch_alarm; // [RULE13]
    rst_ev[fmr_pkg::RC_WDG]    = st_reg.ctrl[fmr_pkg::CTRL_WDG_EN_BIT] &&
                                 (st_reg.wdg_cnt == 32'h0000_0000); // [RULE14]

    // Exception faults
    exc_ev[fmr_pkg::EC_SP_USR]  = sp_bad[0]; // [RULE12]
    exc_ev[fmr_pkg::EC_SP_SYS]  = sp_bad[1];
    exc_ev[fmr_pkg::EC_SP_SUP]  = sp_bad[2];
    exc_ev[fmr_pkg::EC_ECC]     = ee_ecc_err && st_reg.ctrl[fmr_pkg::CTRL_INVECC_BIT]; // [RULE17]
    exc_ev[fmr_pkg::EC_PK_DIS]  = pk_access && st_reg.pdc[fmr_pkg::PDC_PK_DIS_BIT]; // [RULE18]
    exc_ev[fmr_pkg::EC_SYM_DIS] = sym_access && st_reg.pdc[fmr_pkg::PDC_SYM_DIS_BIT]; // [RULE18]

    // Watchdog countdown, reloaded by any write to its load register
    if (st_reg.ctrl[fmr_pkg::CTRL_WDG_EN_BIT] && st_reg.wdg_cnt != 32'h0000_0000) begin
      st_next.wdg_cnt = st_reg.wdg_cnt - 32'h0000_0001; // [RULE14]
    end

    // Scan steals only idle RAM cycles; LFSR gives the random order
    st_next.scan_rd = st_reg.ctrl[fmr_pkg::CTRL_SCAN_EN_BIT] && !ram_busy; // [RULE6]
    if (st_next.scan_rd) begin
      st_next.lfsr = {st_reg.lfsr[14:0],
                      st_reg.lfsr[15] ^ st_reg.lfsr[13] ^ st_reg.lfsr[12] ^ st_reg.lfsr[10]};
    end

    // APB: zero wait, answer in the access cycle
    st_next.pready = psel && !penable;
    st_next.prdata = 32'h0000_0000;

    // Register writes; clear happens first so a same-cycle event wins
    if (wr_acc) begin
      unique case (paddr)
        fmr_pkg::ADDR_RST_CAUSE: st_next.rst_cause = st_reg.rst_cause &
                                   ~pwdata[fmr_pkg::RC_W-1:0]; // [RULE22]
        fmr_pkg::ADDR_EXC_CAUSE: st_next.exc_cause = st_reg.exc_cause &
                                   ~pwdata[fmr_pkg::EC_W-1:0]; // [RULE22]
        fmr_pkg::ADDR_CTRL:      st_next.ctrl = pwdata[3:0]; // [RULE4]
        fmr_pkg::ADDR_WDG_LOAD: begin
          st_next.wdg_load = pwdata;
          st_next.wdg_cnt  = pwdata;
        end
        fmr_pkg::ADDR_HV_STAT:   st_next.hv_stat = st_reg.hv_stat & ~pwdata[1:0];
        fmr_pkg::ADDR_SP_USR_LO: st_next.sp_lo[0] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_SP_USR_HI: st_next.sp_hi[0] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_SP_SYS_LO: st_next.sp_lo[1] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_SP_SYS_HI: st_next.sp_hi[1] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_SP_SUP_LO: st_next.sp_lo[2] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_SP_SUP_HI: st_next.sp_hi[2] = pwdata[fmr_pkg::SP_W-1:0];
        fmr_pkg::ADDR_PDC: begin
          if (!st_reg.pdc_locked) begin
            st_next.pdc = pwdata[1:0]; // [RULE19]
          end
        end
        fmr_pkg::ADDR_PDC_LOCK: begin
          if (pwdata == fmr_pkg::PDC_LOCK_KEY) begin
            st_next.pdc_locked = 1'b1; // [RULE19]
          end
        end
        // Sensor filters have no address at all, so no write can mask them
        default: st_next.ctrl = st_reg.ctrl; // [RULE10]
      endcase
    end

    // High voltage check result; applied after the clear so a set wins
    st_next.hv_seen = ee_write_seq;
    if (ee_write_seq) begin
      st_next.hv_stat[0] = st_next.hv_stat[0] | ~ee_hv_ok; // [RULE15] [RULE16]
    end
    if (st_reg.hv_seen && !ee_write_seq) begin
      st_next.hv_stat[1] = 1'b1; // [RULE15]
    end

    if (rd_acc) begin
      unique case (paddr)
        fmr_pkg::ADDR_RST_CAUSE: rd = {{(32-fmr_pkg::RC_W){1'b0}}, st_reg.rst_cause}; // [RULE8]
        fmr_pkg::ADDR_EXC_CAUSE: rd = {{(32-fmr_pkg::EC_W){1'b0}}, st_reg.exc_cause}; // [RULE9]
        fmr_pkg::ADDR_CTRL:      rd = {28'h000_0000, st_reg.ctrl};
        fmr_pkg::ADDR_WDG_LOAD:  rd = st_reg.wdg_cnt;
        fmr_pkg::ADDR_HV_STAT:   rd = {30'h0000_0000, st_reg.hv_stat}; // [RULE15]
        fmr_pkg::ADDR_SP_USR_LO: rd = {16'h0000, st_reg.sp_lo[0]};
        fmr_pkg::ADDR_SP_USR_HI: rd = {16'h0000, st_reg.sp_hi[0]};
        fmr_pkg::ADDR_SP_SYS_LO: rd = {16'h0000, st_reg.sp_lo[1]};
        fmr_pkg::ADDR_SP_SYS_HI: rd = {16'h0000, st_reg.sp_hi[1]};
        fmr_pkg::ADDR_SP_SUP_LO: rd = {16'h0000, st_reg.sp_lo[2]};
        fmr_pkg::ADDR_SP_SUP_HI: rd = {16'h0000, st_reg.sp_hi[2]};
        fmr_pkg::ADDR_PDC:       rd = {30'h0000_0000, st_reg.pdc};
        fmr_pkg::ADDR_PDC_LOCK:  rd = {31'h0000_0000, st_reg.pdc_locked};
        fmr_pkg::ADDR_SCAN_ADDR: rd = {24'h00_0000, st_reg.lfsr[fmr_pkg::RAM_AW-1:0]};
        default:                 rd = 32'h0000_0000;
      endcase
    end
    st_next.prdata = rd; // [RULE8] [RULE9]

    // Response: reset beats exception; a reset cycle records only reset causes
    st_next.sec_reset = |rst_ev; // [RULE1] [RULE21]
    st_next.exc_req   = !(|rst_ev) && (|exc_ev); // [RULE1] [RULE21]
    st_next.rst_cause = st_next.rst_cause | rst_ev; // [RULE8] [RULE22]
    if (!(|rst_ev)) begin
      st_next.exc_cause = st_next.exc_cause | exc_ev; // [RULE9]
    end
    // Forced reset clears working state at once, so no fault repeats itself
    if (|rst_ev) begin
      st_next.ctrl     = fmr_pkg::CTRL_RST; // [RULE8]
      st_next.wdg_load = fmr_pkg::WDG_LOAD_RST;
      st_next.wdg_cnt  = fmr_pkg::WDG_LOAD_RST;
      st_next.exc_cause = '0;
      st_next.hv_stat  = 2'b00;
      st_next.scan_rd  = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg            <= '0;
      st_reg.ctrl       <= fmr_pkg::CTRL_RST;
      st_reg.wdg_load   <= fmr_pkg::WDG_LOAD_RST;
      st_reg.wdg_cnt    <= fmr_pkg::WDG_LOAD_RST;
      st_reg.lfsr       <= fmr_pkg::LFSR_SEED;
      st_reg.sp_lo      <= {3{fmr_pkg::SP_LO_RST}};
      st_reg.sp_hi      <= {3{fmr_pkg::SP_HI_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pready         = st_reg.pready;
  assign prdata         = st_reg.prdata;
  assign pslverr        = 1'b0;
  assign sec_reset      = st_reg.sec_reset;
  assign exc_req        = st_reg.exc_req;
  assign ee_dread_en    = st_reg.ctrl[fmr_pkg::CTRL_DREAD_BIT]; // [RULE4]
  assign ee_ecc_correct = !st_reg.ctrl[fmr_pkg::CTRL_INVECC_BIT]; // [RULE20]
  assign scan_rd        = st_reg.scan_rd;
  assign scan_addr      = st_reg.lfsr[fmr_pkg::RAM_AW-1:0]; // [RULE6]
  assign pk_enable      = !st_reg.pdc[fmr_pkg::PDC_PK_DIS_BIT];
  assign sym_enable     = !st_reg.pdc[fmr_pkg::PDC_SYM_DIS_BIT];

endmodule

//--- fmr_pkg.sv
// Package: register map, cause codes and constants for the fault monitor
package fmr_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_RST_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_EXC_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_CTRL      = 8'h08;
  localparam logic [7:0] ADDR_WDG_LOAD  = 8'h0c;
  localparam logic [7:0] ADDR_HV_STAT   = 8'h10;
  localparam logic [7:0] ADDR_SP_USR_LO = 8'h14;
  localparam logic [7:0] ADDR_SP_USR_HI = 8'h18;
  localparam logic [7:0] ADDR_SP_SYS_LO = 8'h1c;
  localparam logic [7:0] ADDR_SP_SYS_HI = 8'h20;
  localparam logic [7:0] ADDR_SP_SUP_LO = 8'h24;
  localparam logic [7:0] ADDR_SP_SUP_HI = 8'h28;
  localparam logic [7:0] ADDR_PDC       = 8'h2c;
  localparam logic [7:0] ADDR_PDC_LOCK  = 8'h30;
  localparam logic [7:0] ADDR_SCAN_ADDR = 8'h34;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_DREAD_BIT = 0;
  localparam int CTRL_INVECC_BIT = 1;
  localparam int CTRL_WDG_EN_BIT = 2;
  localparam int CTRL_SCAN_EN_BIT = 3;
  localparam int PDC_PK_DIS_BIT  = 0;
  localparam int PDC_SYM_DIS_BIT = 1;

  // ****************************************
  // Cause bit positions
  // ****************************************
  localparam int RC_VOLT   = 0;
  localparam int RC_CLK    = 1;
  localparam int RC_TEMP   = 2;
  localparam int RC_LIGHT  = 3;
  localparam int RC_RAMPAR = 4;
  localparam int RC_SCANPAR = 5;
  localparam int RC_FETCH  = 6;
  localparam int RC_WDG    = 7;
  localparam int RC_W      = 8;

  localparam int EC_SP_USR = 0;
  localparam int EC_SP_SYS = 1;
  localparam int EC_SP_SUP = 2;
  localparam int EC_ECC    = 3;
  localparam int EC_PK_DIS = 4;
  localparam int EC_SYM_DIS = 5;
  localparam int EC_W      = 6;

  // ****************************************
  // Constants and reset values
  // ****************************************
  localparam logic [31:0] PDC_LOCK_KEY  = 32'h0000_a5c3;
  localparam logic [15:0] LFSR_SEED     = 16'hace1;
  localparam int          FILT_LEN      = 3;
  localparam int          RAM_AW        = 8;
  localparam int          SP_W          = 16;
  localparam logic [3:0]  CTRL_RST      = 4'h8;
  localparam logic [31:0] WDG_LOAD_RST  = 32'h0000_ffff;
  localparam logic [SP_W-1:0] SP_LO_RST = 16'h0000;
  localparam logic [SP_W-1:0] SP_HI_RST = 16'hffff;

  // Stack modes
  typedef enum logic [2:0] {
    FMR_MODE_USR = 3'b001,
    FMR_MODE_SYS = 3'b010,
    FMR_MODE_SUP = 3'b100
  } fmr_mode_t;

endpackage

//--- fmr_sva.sv
// Checker: timing relations on the fault monitor ports
`timescale 1ns/1ps
module fmr_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Fault sources
  input wire logic        volt_alarm,
  input wire logic        light_alarm,
  input wire logic [12:0] fetch_alarm,
  input wire logic        ram_rd,
  input wire logic        ram_par_err,
  input wire logic        ram_busy,
  input wire logic        scan_par_err,
  input wire logic        ee_ecc_err,
  input wire logic        pk_access,
  // Responses
  input wire logic        scan_rd,
  input wire logic        ee_ecc_correct,
  input wire logic        pk_enable,
  input wire logic        sec_reset,
  input wire logic        exc_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Assertions
  // ****************************************
  a_volt_filter: assert property (volt_alarm [*3] |=> ##1 sec_reset)
    else $error("volt alarm gave no reset");
  a_light_fault: assert property (light_alarm [*3] |=> ##1 sec_reset)
    else $error("light alarm gave no reset");
  a_fetch_reset: assert property (|fetch_alarm |=> sec_reset)
    else $error("fetch alarm gave no reset");
  a_ram_parity: assert property (ram_rd && ram_par_err |=> sec_reset)
    else $error("ram parity gave no reset");
  a_scan_parity: assert property (scan_rd && scan_par_err |=> sec_reset)
    else $error("scan parity gave no reset");
  // Scan may only claim cycles that the RAM left idle
  a_scan_idle: assert property (scan_rd |-> !$past(ram_busy))
    else $error("scan read in busy cycle");
  a_reset_wins: assert property (sec_reset |-> !exc_req)
    else $error("exception beside reset");
  a_ecc_raise: assert property (ee_ecc_err && !ee_ecc_correct |=> exc_req || sec_reset)
    else $error("ecc error gave no exception");
  a_pk_blocked: assert property (pk_access && !pk_enable |=> exc_req || sec_reset)
    else $error("disabled coprocessor use gave no exception");
  cover property (sec_reset);
  cover property (exc_req);
  cover property (scan_rd ##1 scan_par_err);
endmodule

bind fmr_monitor fmr_sva fmr_sva_inst (
  .clk(clk), .sys_rst(sys_rst), .volt_alarm(volt_alarm), .light_alarm(light_alarm),
  .fetch_alarm(fetch_alarm), .ram_rd(ram_rd), .ram_par_err(ram_par_err), .ram_busy(ram_busy),
  .scan_par_err(scan_par_err), .ee_ecc_err(ee_ecc_err), .pk_access(pk_access),
  .scan_rd(scan_rd), .ee_ecc_correct(ee_ecc_correct), .pk_enable(pk_enable),
  .sec_reset(sec_reset), .exc_req(exc_req)
);

//--- tb_top.sv
// Testbench: APB sequences and fault stimulus for the fault monitor
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, scan_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, sec_reset, exc_req, ee_dread_en, ee_ecc_correct;
  logic        scan_rd, pk_enable, sym_enable;
  logic [3:0]  sens = 4'h0;
  logic [12:0] fetch_alarm = 13'h0;
  logic        ram_rd = 1'h0, ram_par_err = 1'h0, ram_busy = 1'h0, scan_par_err = 1'h0;
  logic        ee_ecc_err = 1'h0, ee_write_seq = 1'h0, ee_hv_ok = 1'h1;
  logic        pk_access = 1'h0, sym_access = 1'h0;
  logic [2:0]  cpu_mode = 3'h1;
  logic [15:0] sp_value = 16'h0080;
  int          fails = 0, cmp_count = 0, n_rst = 0, n_exc = 0, n;

  always #25 clk = ~clk;

  fmr_monitor fmr_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .volt_alarm(sens[0]), .clk_alarm(sens[1]), .temp_alarm(sens[2]), .light_alarm(sens[3]),
    .fetch_alarm(fetch_alarm), .ram_rd(ram_rd), .ram_par_err(ram_par_err),
    .ram_busy(ram_busy), .scan_par_err(scan_par_err), .cpu_mode(cpu_mode),
    .sp_value(sp_value), .ee_ecc_err(ee_ecc_err), .ee_write_seq(ee_write_seq),
    .ee_hv_ok(ee_hv_ok), .pk_access(pk_access), .sym_access(sym_access),
    .sec_reset(sec_reset), .exc_req(exc_req), .ee_dread_en(ee_dread_en),
    .ee_ecc_correct(ee_ecc_correct), .scan_rd(scan_rd), .scan_addr(scan_addr),
    .pk_enable(pk_enable), .sym_enable(sym_enable)
  );

  // Pulses are counted so that scenarios need not hit the exact cycle
  always @(posedge clk) begin
    if (sec_reset === 1'h1) n_rst++;
    if (exc_req === 1'h1) n_exc++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    tick(2);
  endtask

  task automatic ev(input int er, input int ee);
    chk(n_rst, er);
    chk(n_exc, ee);
    n_rst = 0;
    n_exc = 0;
  endtask

  task automatic cause(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
    apb(1'h1, a, e);
    apb(1'h0, a, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic end_sim;
    $display("checks=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    tick(30000);
    fails++;
    end_sim();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    tick(4);
    sys_rst <= 1'h0;
    tick(1);
    chk({ee_dread_en, ee_ecc_correct, pk_enable, sym_enable}, 32'h7);
    apb(1'h0, fmr_pkg::ADDR_CTRL, 32'h0);
    chk(rd, {28'h0, fmr_pkg::CTRL_RST});
    apb(1'h1, fmr_pkg::ADDR_CTRL, 32'h0);
    apb(1'h1, 8'h3c, 32'hffff_ffff);
    chk(pslverr, 1'h0);
    for (int i = 0; i < 4; i++) begin
      sens <= 4'(1 << i);
      tick(2);
      sens <= 4'h0;
      tick(4);
      ev(0, 0);
      sens <= 4'(1 << i);
      tick(3);
      sens <= 4'h0;
      tick(4);
      ev(1, 0);
      cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << i));
    end
    for (int i = 0; i < 13; i++) begin
      fetch_alarm <= 13'(1 << i);
      tick(1);
      fetch_alarm <= 13'h0;
      tick(3);
      ev(1, 0);
    end
    cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << fmr_pkg::RC_FETCH));
    ram_par_err <= 1'h1;
    tick(1);
    ram_rd <= 1'h1;
    tick(1);
    ram_rd <= 1'h0;
    ram_par_err <= 1'h0;
    tick(3);
    ev(1, 0);
    cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << fmr_pkg::RC_RAMPAR));
    apb(1'h1, fmr_pkg::ADDR_CTRL, 32'h8);
    ram_busy <= 1'h1;
    tick(3);
    n = scan_addr;
    repeat (20) begin
      tick(1);
      chk(scan_rd, 1'h0);
      chk(scan_addr, n);
    end
    ram_busy <= 1'h0;
    n = 0;
    do tick(1); while (scan_rd !== 1'h1 && ++n < 50);
    chk(scan_rd, 1'h1);
    scan_par_err <= 1'h1;
    tick(1);
    scan_par_err <= 1'h0;
    tick(3);
    ev(1, 0);
    cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << fmr_pkg::RC_SCANPAR));
    for (int m = 0; m < 3; m++) begin
      apb(1'h1, 8'(fmr_pkg::ADDR_SP_USR_HI + 8 * m), 32'h100);
      cpu_mode <= 3'(1 << ((m + 1) % 3));
      sp_value <= 16'h0101;
      tick(1);
      cpu_mode <= 3'(1 << m);
      sp_value <= 16'h0100;
      tick(1);
      sp_value <= 16'h0101;
      tick(1);
      sp_value <= 16'h0080;
      tick(3);
      ev(0, 1);
      cause(fmr_pkg::ADDR_EXC_CAUSE, 32'(1 << m));
      apb(1'h1, 8'(fmr_pkg::ADDR_SP_USR_HI + 8 * m), 32'hffff);
    end
    apb(1'h1, fmr_pkg::ADDR_SP_SUP_HI, 32'h100);
    sp_value <= 16'h0200;
    ram_rd <= 1'h1;
    ram_par_err <= 1'h1;
    tick(1);
    sp_value <= 16'h0080;
    ram_rd <= 1'h0;
    ram_par_err <= 1'h0;
    tick(3);
    ev(1, 0);
    cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << fmr_pkg::RC_RAMPAR));
    apb(1'h1, fmr_pkg::ADDR_SP_SUP_HI, 32'hffff);
    apb(1'h1, fmr_pkg::ADDR_CTRL, 32'h9);
    chk({ee_dread_en, ee_ecc_correct}, 32'h3);
    for (int v = 0; v < 2; v++) begin
      ee_ecc_err <= 1'h1;
      tick(1);
      ee_ecc_err <= 1'h0;
      tick(3);
      ev(0, v);
      apb(1'h1, fmr_pkg::ADDR_CTRL, 32'ha);
      chk({ee_dread_en, ee_ecc_correct}, 32'h0);
    end
    cause(fmr_pkg::ADDR_EXC_CAUSE, 32'(1 << fmr_pkg::EC_ECC));
    ee_hv_ok <= 1'h0;
    ee_write_seq <= 1'h1;
    tick(4);
    ee_write_seq <= 1'h0;
    ee_hv_ok <= 1'h1;
    tick(3);
    ev(0, 0);
    cause(fmr_pkg::ADDR_HV_STAT, 32'h3);
    apb(1'h1, fmr_pkg::ADDR_WDG_LOAD, 32'h14);
    tick(40);
    ev(0, 0);
    apb(1'h1, fmr_pkg::ADDR_CTRL, 32'hc);
    n = 0;
    while (n_rst == 0 && n++ < 100) tick(1);
    apb(1'h1, fmr_pkg::ADDR_CTRL, 32'h8);
    ev(1, 0);
    cause(fmr_pkg::ADDR_RST_CAUSE, 32'(1 << fmr_pkg::RC_WDG));
    for (int d = 1; d < 3; d++) begin
      apb(1'h1, fmr_pkg::ADDR_PDC, 32'(d));
      chk({pk_enable, sym_enable}, 32'(d));
      pk_access <= 1'h1;
      sym_access <= 1'h1;
      tick(1);
      pk_access <= 1'h0;
      sym_access <= 1'h0;
      tick(3);
      ev(0, 1);
      cause(fmr_pkg::ADDR_EXC_CAUSE, 32'(1 << (fmr_pkg::EC_PK_DIS + d - 1)));
    end
    apb(1'h1, fmr_pkg::ADDR_PDC, 32'h1);
    apb(1'h1, fmr_pkg::ADDR_PDC_LOCK, fmr_pkg::PDC_LOCK_KEY);
    apb(1'h1, fmr_pkg::ADDR_PDC, 32'h0);
    chk({pk_enable, sym_enable}, 32'h1);
    // A forced reset must not reopen the locked configuration
    fetch_alarm <= 13'h1;
    tick(1);
    fetch_alarm <= 13'h0;
    tick(3);
    apb(1'h1, fmr_pkg::ADDR_PDC, 32'h0);
    chk({pk_enable, sym_enable}, 32'h1);
    end_sim();
  end
endmodule
